// ==== design/rcs_pkg.sv ====
// constants and register map of the reset cause recorder
package rcs_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int WAKE_W = 8;
  // register indices; byte address is four times the index
  localparam logic [9:0] REG_PRIMARY_IDX = 10'h000;
  localparam logic [9:0] REG_EXTENDED_IDX = 10'h001;
  localparam logic [9:0] REG_IRQ_STATUS_IDX = 10'h002;
  localparam logic [9:0] REG_IRQ_MASK_IDX = 10'h003;
  // primary cause register fields
  localparam int PRI_WAKE_BIT = 0;
  localparam int PRI_UNDERVOLT_BIT = 1;
  localparam int PRI_CLKLOSS_BIT = 2;
  localparam int PRI_POWERON_BIT = 7;
  // extended cause register fields
  localparam int EXT_LOCKUP_BIT = 1;
  localparam int EXT_SOFTWARE_BIT = 2;
  localparam int EXT_DEBUGGER_BIT = 3;
  localparam int EXT_STOPACK_BIT = 5;
  localparam logic [7:0] EXT_USED_MASK = 8'h2e;
  // reset values and fixed capture values
  localparam logic [7:0] PRIMARY_POR_VALUE = 8'h82;
  localparam logic [7:0] PRIMARY_UNDERVOLT_VALUE = 8'h02;
  localparam logic [7:0] PRIMARY_WAKE_VALUE = 8'h01;
  localparam logic [7:0] EXTENDED_RESET_VALUE = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  // interrupt status fields
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_UNDERVOLT_BIT = 1;
  localparam int IRQ_CLKLOSS_BIT = 2;
  localparam int IRQ_DEBUGGER_BIT = 3;
  localparam int IRQ_SOFTWARE_BIT = 4;
  localparam int IRQ_STOPACK_BIT = 5;
  localparam int IRQ_LOCKUP_BIT = 6;
  // timing
  localparam longint CLK_HZ = 25_000_000;
  localparam longint STOP_ACK_TIME_MS = 1000;
  localparam int STOP_ACK_CYCLES = int'((CLK_HZ * STOP_ACK_TIME_MS) / 1000);
endpackage

// ==== design/rcs_reset_cause_status.sv ====
// reset cause recorder with apb register access and event interrupt
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
//
// Function
// - bit 2 of primary set on loss of external clock, else cleared
// - clock loss only counts while the clock monitor is enabled
// - enabled undervoltage trip causes reset and sets primary bit 1
// - power-on reset also sets the undervoltage flag
// - bit 0 of primary set by enabled wake source in low-leakage mode
// - in leakage stop mode only the reset pin gives a wake reset
// - in deep leakage stop modes any enabled wake source gives one
// - wake flag cleared by every reset other than a wake reset
// - extended register reads zero after power-on, undervoltage or wake
// - otherwise only the flags of the actual sources are set
// - extended bit 5 set after stop acknowledge timeout of one second
// - extended bit 3 set on debugger system reset request
// - extended bit 2 set on software system reset request
// - extended bit 1 set on core lockup
// - extended bits 7, 6, 4 and 0 read as zero
// - both cause registers are read-only, reset state set by cause
// - after power-on the primary register reads 0x82
module rcs_reset_cause_status #(
  parameter int STOP_ACK_CYCLES = rcs_pkg::STOP_ACK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rcs_pkg::ADDR_W-1:0] paddr,
  input wire logic [rcs_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [rcs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clock_loss_detect,
  input wire logic clock_monitor_enable,
  input wire logic undervoltage_trip,
  input wire logic undervoltage_reset_enable,
  input wire logic leakage_stop_mode,
  input wire logic deep_leakage_stop_modes,
  input wire logic reset_pin_assert,
  input wire logic [rcs_pkg::WAKE_W-1:0] wake_source,
  input wire logic [rcs_pkg::WAKE_W-1:0] wake_source_enable,
  input wire logic stop_entry_pending,
  input wire logic stop_ack_all,
  input wire logic debugger_request,
  input wire logic core_system_reset_request,
  input wire logic core_lockup,
  output logic system_reset_request,
  output logic irq
);
  import rcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // qualified reset sources

  logic clock_loss_cause;
  logic undervoltage_cause;
  logic leakage_wake_unit;
  logic stop_ack_timeout_cause;
  logic debugger_request_cause;
  logic software_request_cause;
  logic core_lockup_cause;
  logic any_cause;
  logic [31:0] stop_wait_count;

  // the monitor gate keeps a disabled monitor from ever resetting the chip
  assign clock_loss_cause = clock_loss_detect & clock_monitor_enable;
  assign undervoltage_cause = undervoltage_trip & undervoltage_reset_enable;
  // leakage stop only listens to the pin, deep modes to any enabled source
  assign leakage_wake_unit = (leakage_stop_mode & reset_pin_assert)
    | (deep_leakage_stop_modes & (|(wake_source & wake_source_enable)));
  assign stop_ack_timeout_cause = stop_entry_pending & ~stop_ack_all
    & (stop_wait_count == 32'(STOP_ACK_CYCLES - 1));
  assign debugger_request_cause = debugger_request;
  assign software_request_cause = core_system_reset_request;
  assign core_lockup_cause = core_lockup;
  assign any_cause = clock_loss_cause | undervoltage_cause | leakage_wake_unit
    | stop_ack_timeout_cause | debugger_request_cause | software_request_cause
    | core_lockup_cause;

  // stop acknowledge watchdog; restarts whenever the request is dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stop_wait_count <= 32'h0000_0000;
    else if (!stop_entry_pending || stop_ack_all || stop_ack_timeout_cause)
      stop_wait_count <= 32'h0000_0000;
    else
      stop_wait_count <= stop_wait_count + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // cause capture

  logic [7:0] reset_cause_primary;
  logic [7:0] reset_cause_extended;
  logic [7:0] next_primary;
  logic [7:0] next_extended;

  // undervoltage outranks wake, wake outranks the ordinary sources
  always_comb
  begin
    next_primary = 8'h00;
    next_extended = 8'h00;
    if (undervoltage_cause)
    begin
      next_primary = PRIMARY_UNDERVOLT_VALUE;
    end
    else if (leakage_wake_unit)
    begin
      next_primary = PRIMARY_WAKE_VALUE;
    end
    else
    begin
      next_primary[PRI_CLKLOSS_BIT] = clock_loss_cause;
      next_extended[EXT_STOPACK_BIT] = stop_ack_timeout_cause;
      next_extended[EXT_DEBUGGER_BIT] = debugger_request_cause;
      next_extended[EXT_SOFTWARE_BIT] = software_request_cause;
      next_extended[EXT_LOCKUP_BIT] = core_lockup_cause;
    end
  end

  // presetn is the power-on reset; other causes load on the reset request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_cause_primary <= PRIMARY_POR_VALUE;
      reset_cause_extended <= EXTENDED_RESET_VALUE;
    end
    else if (any_cause)
    begin
      reset_cause_primary <= next_primary;
      reset_cause_extended <= next_extended & EXT_USED_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      system_reset_request <= 1'b0;
    else
      system_reset_request <= any_cause;
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] irq_events;
  logic wr_access;
  logic [9:0] word_index;

  assign irq_events = {core_lockup_cause, stop_ack_timeout_cause,
    software_request_cause, debugger_request_cause, clock_loss_cause,
    undervoltage_cause, leakage_wake_unit} == 7'h00 ? 8'h00 :
    {1'b0, core_lockup_cause, stop_ack_timeout_cause, software_request_cause,
    debugger_request_cause, clock_loss_cause, undervoltage_cause, leakage_wake_unit};
  assign word_index = paddr[11:2];
  assign wr_access = psel & penable & pwrite & pstrb[0];

  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= IRQ_STATUS_RESET;
    else if (wr_access && word_index == REG_IRQ_STATUS_IDX)
      irq_status <= (irq_status & ~pwdata[7:0]) | irq_events;
    else
      irq_status <= irq_status | irq_events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= IRQ_MASK_RESET;
    else if (wr_access && word_index == REG_IRQ_MASK_IDX)
      irq_mask <= pwdata[7:0];
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data loaded in the setup cycle

  logic mapped;

  assign pready = 1'b1;
  assign mapped = paddr[1:0] == 2'h0 && word_index <= REG_IRQ_MASK_IDX;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= ~mapped;
      prdata <= 32'h0000_0000;
      if (!pwrite && mapped)
      begin
        unique case (word_index)
          REG_PRIMARY_IDX: prdata <= {24'h00_0000, reset_cause_primary};
          REG_EXTENDED_IDX: prdata <= {24'h00_0000, reset_cause_extended};
          REG_IRQ_STATUS_IDX: prdata <= {24'h00_0000, irq_status};
          REG_IRQ_MASK_IDX: prdata <= {24'h00_0000, irq_mask};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
    else if (!psel)
    begin
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_clock_loss;
    clock_loss_detect && clock_monitor_enable && !undervoltage_cause && !leakage_wake_unit
      |=> reset_cause_primary[PRI_CLKLOSS_BIT] && system_reset_request;
  endproperty
  a_clock_loss: assert property (p_clock_loss) else $error("clock loss not recorded");

  property p_monitor_off;
    any_cause && !clock_monitor_enable |=> !reset_cause_primary[PRI_CLKLOSS_BIT];
  endproperty
  a_monitor_off: assert property (p_monitor_off) else $error("clock loss with monitor off");

  property p_undervolt;
    undervoltage_trip && undervoltage_reset_enable
      |=> reset_cause_primary == 8'h02 && reset_cause_extended == 8'h00 && system_reset_request;
  endproperty
  a_undervolt: assert property (p_undervolt) else $error("undervoltage capture wrong");

  property p_pin_wake;
    leakage_stop_mode && !deep_leakage_stop_modes && reset_pin_assert && !undervoltage_cause
      |=> reset_cause_primary == 8'h01 && reset_cause_extended == 8'h00;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake not recorded");

  property p_deep_wake;
    deep_leakage_stop_modes && (|(wake_source & wake_source_enable)) && !undervoltage_cause
      |=> reset_cause_primary == 8'h01;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("deep wake not recorded");

  property p_wake_cleared;
    any_cause && !leakage_wake_unit |=> !reset_cause_primary[PRI_WAKE_BIT];
  endproperty
  a_wake_cleared: assert property (p_wake_cleared) else $error("wake flag left set");

  property p_only_actual;
    any_cause && !undervoltage_cause && !leakage_wake_unit
      |=> reset_cause_extended == ({2'h0, $past(stop_ack_timeout_cause), 1'b0,
        $past(debugger_request), $past(core_system_reset_request), $past(core_lockup), 1'b0});
  endproperty
  a_only_actual: assert property (p_only_actual) else $error("extended flags wrong");

  property p_stop_timeout;
    stop_ack_timeout_cause |-> stop_wait_count == 32'(STOP_ACK_CYCLES - 1)
      ##1 reset_cause_extended[EXT_STOPACK_BIT] || $past(undervoltage_cause || leakage_wake_unit);
  endproperty
  a_stop_timeout: assert property (p_stop_timeout) else $error("stop timeout not recorded");

  property p_reserved;
    (reset_cause_extended & ~EXT_USED_MASK) == 8'h00 && reset_cause_primary[6:3] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_hold;
    !any_cause |=> $stable(reset_cause_primary) && $stable(reset_cause_extended);
  endproperty
  a_hold: assert property (p_hold) else $error("cause changed without reset");

  property p_debugger;
    debugger_request && !undervoltage_cause && !leakage_wake_unit
      |=> reset_cause_extended[EXT_DEBUGGER_BIT];
  endproperty
  a_debugger: assert property (p_debugger) else $error("debugger request not recorded");

  property p_software;
    core_system_reset_request && !undervoltage_cause && !leakage_wake_unit
      |=> reset_cause_extended[EXT_SOFTWARE_BIT];
  endproperty
  a_software: assert property (p_software) else $error("software request not recorded");

  property p_lockup;
    core_lockup && !undervoltage_cause && !leakage_wake_unit
      |=> reset_cause_extended[EXT_LOCKUP_BIT];
  endproperty
  a_lockup: assert property (p_lockup) else $error("core lockup not recorded");

  // undervoltage and wake captures must wipe any older extended flags
  property p_ext_zero;
    undervoltage_cause || leakage_wake_unit
      |=> reset_cause_extended == EXTENDED_RESET_VALUE;
  endproperty
  a_ext_zero: assert property (p_ext_zero) else $error("extended not zero");

  property p_poweron_cleared;
    any_cause |=> !reset_cause_primary[PRI_POWERON_BIT];
  endproperty
  a_poweron_cleared: assert property (p_poweron_cleared) else $error("power-on flag kept");

  property p_wake_value;
    leakage_wake_unit && !undervoltage_cause
      |=> reset_cause_primary == PRIMARY_WAKE_VALUE;
  endproperty
  a_wake_value: assert property (p_wake_value) else $error("wake value wrong");

  // a bus write must never reach the cause flags
  property p_read_only;
    psel && penable && pwrite && word_index <= REG_EXTENDED_IDX && !any_cause
      |=> $stable(reset_cause_primary) && $stable(reset_cause_extended);
  endproperty
  a_read_only: assert property (p_read_only) else $error("cause register written");

  property p_request_out;
    any_cause |=> system_reset_request;
  endproperty
  a_request_out: assert property (p_request_out) else $error("reset request missing");

  property p_request_idle;
    !any_cause |=> !system_reset_request;
  endproperty
  a_request_idle: assert property (p_request_idle) else $error("spurious reset request");

  property p_lockup_event;
    core_lockup |=> irq_status[IRQ_LOCKUP_BIT];
  endproperty
  a_lockup_event: assert property (p_lockup_event) else $error("lockup event lost");

  property p_ext_read;
    psel && !penable && !pwrite && paddr[1:0] == 2'h0 && word_index == REG_EXTENDED_IDX
      |=> prdata == {24'h00_0000, $past(reset_cause_extended)};
  endproperty
  a_ext_read: assert property (p_ext_read) else $error("extended read wrong");

  property p_pri_read;
    psel && !penable && !pwrite && paddr[1:0] == 2'h0 && word_index == REG_PRIMARY_IDX
      |=> prdata == {24'h00_0000, $past(reset_cause_primary)};
  endproperty
  a_pri_read: assert property (p_pri_read) else $error("primary read wrong");

  property p_unmapped;
    psel && !penable && !mapped
      |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_clock_loss_clear;
    any_cause && !clock_loss_cause |=> !reset_cause_primary[PRI_CLKLOSS_BIT];
  endproperty
  a_clock_loss_clear: assert property (p_clock_loss_clear) else $error("clock loss flag kept");

  // an acknowledge restarts the one second wait from zero
  property p_stop_restart;
    stop_ack_all |=> stop_wait_count == 32'h0000_0000;
  endproperty
  a_stop_restart: assert property (p_stop_restart) else $error("stop wait not restarted");

  property p_mask_write;
    wr_access && word_index == REG_IRQ_MASK_IDX
      |=> irq_mask == $past(pwdata[7:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

endmodule // rcs_reset_cause_status

// ==== sim/rcs_testbench.sv ====
// self-checking testbench of the reset cause recorder
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  import rcs_pkg::*;
  // short stop timeout keeps the run brief
  localparam int N = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, srr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] src;
  logic [7:0] wen;
  int n_errors, compares, cyc;
  ////////////////////////////////////////////////////////////////
  rcs_reset_cause_status #(.STOP_ACK_CYCLES(N)) u_rcs_reset_cause_status (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clock_loss_detect(src[0]), .clock_monitor_enable(src[1]),
    .undervoltage_trip(src[2]), .undervoltage_reset_enable(src[3]),
    .leakage_stop_mode(src[4]), .deep_leakage_stop_modes(src[5]),
    .reset_pin_assert(src[6]), .wake_source(src[19:12]), .wake_source_enable(wen),
    .stop_entry_pending(src[7]), .stop_ack_all(src[8]), .debugger_request(src[9]),
    .core_system_reset_request(src[10]), .core_lockup(src[11]),
    .system_reset_request(srr), .irq(irq)
  );
  ////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [9:0] idx, input logic [7:0] e);
    apb(1'b0, {idx, 2'b00}, 32'h0);
    `CHK("register read", {24'h0, e}, rd)
  endtask
  // cause inputs last one edge only, so a flag must be latched to survive
  task automatic fire(input logic [19:0] s, input logic [7:0] ep, input logic [7:0] ee);
    @(posedge pclk);
    src <= s;
    @(posedge pclk);
    src <= '0;
    rchk(REG_PRIMARY_IDX, ep);
    rchk(REG_EXTENDED_IDX, ee);
  endtask
  task automatic hold(input logic [19:0] s, input int n);
    src <= s;
    repeat (n) @(posedge pclk);
    src <= '0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    src = '0;
    wen = 8'h0f;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(REG_PRIMARY_IDX, 8'h82);
    rchk(REG_EXTENDED_IDX, 8'h00);
    apb(1'b1, 12'h000, 32'hff);
    rchk(REG_PRIMARY_IDX, 8'h82);
    fire(20'h00800, 8'h00, 8'h02);
    fire(20'h00400, 8'h00, 8'h04);
    fire(20'h00200, 8'h00, 8'h08);
    fire(20'h00e00, 8'h00, 8'h0e);
    fire(20'h00001, 8'h00, 8'h0e);
    fire(20'h00003, 8'h04, 8'h00);
    fire(20'h00004, 8'h04, 8'h00);
    fire(20'h0000c, 8'h02, 8'h00);
    fire(20'h01020, 8'h01, 8'h00);
    fire(20'h00800, 8'h00, 8'h02);
    fire(20'h10020, 8'h00, 8'h02);
    fire(20'h01010, 8'h00, 8'h02);
    fire(20'h00050, 8'h01, 8'h00);
    hold(20'h00180, N + 2);
    rchk(REG_EXTENDED_IDX, 8'h00);
    hold(20'h00080, N - 3);
    rchk(REG_EXTENDED_IDX, 8'h00);
    fire(20'h00000, 8'h01, 8'h00);
    hold(20'h00080, N + 2);
    rchk(REG_EXTENDED_IDX, 8'h20);
    repeat (5) @(posedge pclk);
    rchk(REG_PRIMARY_IDX, 8'h00);
    // irq: clear history, unmask lockup, raise, clear
    apb(1'b1, {REG_IRQ_STATUS_IDX, 2'b00}, 32'hff);
    apb(1'b1, {REG_IRQ_MASK_IDX, 2'b00}, 32'h40);
    fire(20'h00400, 8'h00, 8'h04);
    `CHK("irq masked", 1'b0, irq)
    fire(20'h00800, 8'h00, 8'h02);
    rchk(REG_IRQ_STATUS_IDX, 8'h50);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, {REG_IRQ_STATUS_IDX, 2'b00}, 32'h40);
    @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b0, 12'h040, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(REG_PRIMARY_IDX, 8'h82);
    rchk(REG_EXTENDED_IDX, 8'h00);
    `CHK("irq after reset", 1'b0, irq)
    complete_run();
  end
endmodule // testbench
